// ===== dct_cfg.svh
/*
 * Offsets, reset values, field codes and filter widths of the carrier timer pair.
 * Assumes inclusion by bare name from the top module.
 */
`ifndef DCT_CFG_SVH
`define DCT_CFG_SVH

`define DCT_T8_CTRL_IDX    3'h0
`define DCT_SHARED_IDX     3'h1
`define DCT_T16_CTRL_IDX   3'h2
`define DCT_T16_RLD_HI_IDX 3'h3
`define DCT_T16_RLD_LO_IDX 3'h4
`define DCT_T8_RLD_IDX     3'h5

`define DCT_CTRL_RST       8'h00
`define DCT_SHARED_RST     8'h00
`define DCT_RLD_RST        8'h00

`define DCT_SUB_NORMAL     2'h0
`define DCT_SUB_ALT        2'h1
`define DCT_SUB_FORCE0     2'h2
`define DCT_SUB_FORCE1     2'h3

`define DCT_FN_AND         2'h0
`define DCT_FN_OR          2'h1
`define DCT_FN_NOR         2'h2
`define DCT_FN_NAND        2'h3

`define DCT_EDGE_FALL      2'h0
`define DCT_EDGE_RISE      2'h1

`define DCT_FILT_W0        5'h01
`define DCT_FILT_W1        5'h04
`define DCT_FILT_W2        5'h08
`define DCT_FILT_W3        5'h10

`endif

// ===== dct_pkg.sv
/*
 * Types of the carrier timer pair: control register layouts and bus states.
 * Assumes nothing beyond the constants header.
 */
package dct_pkg;
	typedef struct packed {
		logic       en;
		logic       single;
		logic       status;
		logic       init;
		logic [1:0] rsv;
		logic       irq_en;
		logic       pin_en;
	} dct_tctrl_s;

	typedef struct packed {
		logic       mode;
		logic       pin_sel;
		logic [1:0] func;
		logic [1:0] sub;
		logic       rsv;
		logic       init;
	} dct_shared_s;

	typedef enum logic [1:0] {
		DCT_IDLE = 2'b01,
		DCT_ACK  = 2'b10
	} dct_bus_e;
endpackage

// ===== dct_timer_pair.sv
/*
 * Paired 8-bit and 16-bit carrier down-counters with demodulation front end,
 * registers on an Avalon-MM slave with waitrequest.
 * Assumes port data inputs are on clk_i; demodulation pins are asynchronous.
 */
`timescale 1ns/100ps
`include "dct_cfg.svh"

module dct_timer_pair
	import dct_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        ce_i,
	input  wire logic [4:0]  address_i,
	input  wire logic        read_i,
	input  wire logic        write_i,
	input  wire logic [31:0] writedata_i,
	input  wire logic [3:0]  byteenable_i,
	output logic      [31:0] readdata_o,
	output logic             waitrequest_o,
	input  wire logic [2:0]  port_data_i,
	input  wire logic        demod_pin_a_i,
	input  wire logic        demod_pin_b_i,
	input  wire logic        pin_b_mask_i,
	output logic             timer8_out_pin_o,
	output logic             timer16_out_pin_o,
	output logic             combined_out_pin_o,
	output logic             timer8_irq_o,
	output logic             timer16_irq_o,
	output logic             pin_b_interrupt_o
);
	// ************************************************************
	// bus slave
	// ************************************************************
	dct_bus_e    bus_reg;
	logic        wait_reg;
	logic [31:0] rdata_reg;
	dct_tctrl_s  tctrl_reg [2];
	dct_shared_s shared_reg;
	logic [7:0]  rld_hi_reg;
	logic [7:0]  rld_lo_reg;
	logic [7:0]  rld8_reg;
	logic        fall_reg;
	logic [15:0] cnt_reg [2];
	logic [1:0]  tout_reg;

	wire       req    = read_i | write_i;
	wire [2:0] idx    = address_i[4:2];
	wire       we     = ce_i & (bus_reg == DCT_ACK) & write_i & byteenable_i[0];
	wire [7:0] wb     = writedata_i[7:0];
	wire       we_t8  = we & (idx == `DCT_T8_CTRL_IDX);
	wire       we_sh  = we & (idx == `DCT_SHARED_IDX);
	wire       we_t16 = we & (idx == `DCT_T16_CTRL_IDX);
	wire       tx     = ~shared_reg.mode;
	wire       alt    = tx & (shared_reg.sub == `DCT_SUB_ALT);
	wire       force16 = tx & shared_reg.sub[1];
	wire       sh_d0  = tx ? shared_reg.init : fall_reg;
	wire [7:0] rd_byte =
		(idx == `DCT_T8_CTRL_IDX)    ? tctrl_reg[0] :
		(idx == `DCT_SHARED_IDX)     ? {shared_reg[7:1], sh_d0} :
		(idx == `DCT_T16_CTRL_IDX)   ? tctrl_reg[1] :
		(idx == `DCT_T16_RLD_HI_IDX) ? rld_hi_reg :
		(idx == `DCT_T16_RLD_LO_IDX) ? rld_lo_reg :
		(idx == `DCT_T8_RLD_IDX)     ? rld8_reg : 8'h00;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bus_reg   <= DCT_IDLE;
			wait_reg  <= 1'b1;
			rdata_reg <= 32'h0;
		end else if (ce_i) begin
			unique case (bus_reg)
				DCT_IDLE: begin
					if (req) begin
						bus_reg   <= DCT_ACK;
						wait_reg  <= 1'b0;
						rdata_reg <= {24'h0, rd_byte};
					end
				end
				DCT_ACK: begin
					bus_reg  <= DCT_IDLE;
					wait_reg <= 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			shared_reg <= `DCT_SHARED_RST;
			rld_hi_reg <= `DCT_RLD_RST;
			rld_lo_reg <= `DCT_RLD_RST;
			rld8_reg   <= `DCT_RLD_RST;
		end else begin
			if (we_sh) begin
				shared_reg <= {wb[7:1], tx ? wb[0] : shared_reg.init};
			end
			if (we & (idx == `DCT_T16_RLD_HI_IDX)) begin
				rld_hi_reg <= wb;
			end
			if (we & (idx == `DCT_T16_RLD_LO_IDX)) begin
				rld_lo_reg <= wb;
			end
			if (we & (idx == `DCT_T8_RLD_IDX)) begin
				rld8_reg <= wb;
			end
		end
	end

	// ************************************************************
	// demodulation front end
	// ************************************************************
	logic [1:0] sync_a_reg;
	logic [1:0] sync_b_reg;
	logic       filt_reg;
	logic       filt_d_reg;
	logic [4:0] gcnt_reg;

	wire       raw_in = shared_reg.pin_sel ? sync_b_reg[1] : sync_a_reg[1];
	wire [4:0] glim   = (shared_reg.sub == 2'h0) ? `DCT_FILT_W0 :
	                    (shared_reg.sub == 2'h1) ? `DCT_FILT_W1 :
	                    (shared_reg.sub == 2'h2) ? `DCT_FILT_W2 : `DCT_FILT_W3;
	wire       fall_e = filt_d_reg & ~filt_reg;
	wire       rise_e = ~filt_d_reg & filt_reg;
	wire       capt   = ~tx & ((shared_reg.func == `DCT_EDGE_FALL) ? fall_e :
	                    (shared_reg.func == `DCT_EDGE_RISE) ? rise_e : (fall_e | rise_e));

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sync_a_reg <= 2'h0;
			sync_b_reg <= 2'h0;
			filt_reg   <= 1'b0;
			filt_d_reg <= 1'b0;
			gcnt_reg   <= 5'h0;
			fall_reg   <= 1'b0;
		end else if (ce_i) begin
			sync_a_reg <= {sync_a_reg[0], demod_pin_a_i};
			sync_b_reg <= {sync_b_reg[0], demod_pin_b_i};
			filt_d_reg <= filt_reg;
			if (raw_in == filt_reg) begin
				gcnt_reg <= 5'h0;
			end else if (gcnt_reg + 5'h1 >= glim) begin
				filt_reg <= raw_in;
				gcnt_reg <= 5'h0;
			end else begin
				gcnt_reg <= gcnt_reg + 5'h1;
			end
			if (~tx & fall_e) begin
				fall_reg <= 1'b1;
			end else if (we_sh & ~tx & wb[0]) begin
				fall_reg <= 1'b0;
			end
		end
	end

	// ************************************************************
	// counters
	// ************************************************************
	logic [1:0]  term;
	logic [1:0]  load;
	logic [1:0]  en_next;
	logic [1:0]  init_lvl;
	logic [15:0] rld [2];

	assign rld[0]      = {8'h00, rld8_reg};
	assign rld[1]      = {rld_hi_reg, rld_lo_reg};
	assign init_lvl[0] = tctrl_reg[0].init;
	assign init_lvl[1] = shared_reg.init;

	genvar i;
	generate
		for (i = 0; i < 2; i++) begin : g_tmr
			wire wr = (i == 0) ? we_t8 : we_t16;
			assign term[i] = tx & tctrl_reg[i].en & (cnt_reg[i] == 16'h0);
			assign en_next[i] = (alt & term[1-i]) ? 1'b1 :
			                    (term[i] & tctrl_reg[i].single) ? 1'b0 :
			                    wr ? wb[7] : tctrl_reg[i].en;
			assign load[i] = ce_i & en_next[i] & ~tctrl_reg[i].en;

			always_ff @(posedge clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					tctrl_reg[i] <= `DCT_CTRL_RST;
					cnt_reg[i]   <= 16'h0;
					tout_reg[i]  <= 1'b0;
				end else if (ce_i) begin
					if (wr) begin
						tctrl_reg[i] <= {wb[7:6], tctrl_reg[i].status, wb[4:0]};
					end
					tctrl_reg[i].en <= en_next[i];
					if (term[i]) begin
						tctrl_reg[i].status <= 1'b1;
					end else if (wr & wb[5]) begin
						tctrl_reg[i].status <= 1'b0;
					end
					if (load[i]) begin
						cnt_reg[i]  <= rld[i];
						tout_reg[i] <= init_lvl[i];
					end else if (term[i]) begin
						cnt_reg[i]  <= tctrl_reg[i].single ? cnt_reg[i] : rld[i];
						tout_reg[i] <= ~tout_reg[i];
					end else if (tctrl_reg[i].en & tx) begin
						cnt_reg[i] <= cnt_reg[i] - 16'h1;
					end else if (~tctrl_reg[i].en) begin
						tout_reg[i] <= ~init_lvl[i];
					end
				end
			end
		end
	endgenerate

	// ************************************************************
	// output logic
	// ************************************************************
	// forced timer16 level
	wire t16_eff = force16 ? shared_reg.sub[0] : tout_reg[1];
	wire t8_eff  = tout_reg[0];
	wire comb    = (shared_reg.func == `DCT_FN_AND) ? (t8_eff & t16_eff) :
	               (shared_reg.func == `DCT_FN_OR)  ? (t8_eff | t16_eff) :
	               (shared_reg.func == `DCT_FN_NOR) ? ~(t8_eff | t16_eff) :
	               ~(t8_eff & t16_eff);

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			timer8_out_pin_o   <= 1'b0;
			timer16_out_pin_o  <= 1'b0;
			combined_out_pin_o <= 1'b0;
			timer8_irq_o       <= 1'b0;
			timer16_irq_o      <= 1'b0;
			pin_b_interrupt_o  <= 1'b0;
		end else if (ce_i) begin
			timer8_out_pin_o   <= tctrl_reg[0].pin_en ? t8_eff : port_data_i[0];
			timer16_out_pin_o  <= tctrl_reg[1].pin_en ? t16_eff : port_data_i[1];
			combined_out_pin_o <= (tx & shared_reg.pin_sel) ? comb : port_data_i[2];
			timer8_irq_o       <= term[0] & tctrl_reg[0].irq_en;
			timer16_irq_o      <= term[1] & tctrl_reg[1].irq_en;
			pin_b_interrupt_o  <= capt & shared_reg.pin_sel & ~pin_b_mask_i;
		end
	end

	assign readdata_o    = rdata_reg;
	assign waitrequest_o = wait_reg;

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	property p_bus_ack;
		(bus_reg == DCT_IDLE) & req & ce_i |=> !waitrequest_o ##1 waitrequest_o;
	endproperty
	a_bus_ack: assert property (p_bus_ack) else $error("bus answer late");

	property p_fall_flag;
		ce_i & ~tx & fall_e |=> fall_reg;
	endproperty
	a_fall_flag: assert property (p_fall_flag) else $error("falling flag lost");

	property p_force;
		ce_i & force16 & tctrl_reg[1].pin_en |=> timer16_out_pin_o == $past(shared_reg.sub[0]);
	endproperty
	a_force: assert property (p_force) else $error("force level wrong");

	property p_idle;
		ce_i & ~tctrl_reg[1].en & ~en_next[1] |=> tout_reg[1] == ~$past(shared_reg.init);
	endproperty
	a_idle: assert property (p_idle) else $error("idle level wrong");

	property p_load;
		load[1] |=> cnt_reg[1] == $past(rld[1]) && tout_reg[1] == $past(shared_reg.init);
	endproperty
	a_load: assert property (p_load) else $error("load wrong");

	property p_status;
		ce_i & term[1] |=> tctrl_reg[1].status && tout_reg[1] != $past(tout_reg[1]);
	endproperty
	a_status: assert property (p_status) else $error("timeout effects missing");

	property p_single;
		ce_i & term[0] & tctrl_reg[0].single & ~alt |=> !tctrl_reg[0].en;
	endproperty
	a_single: assert property (p_single) else $error("single pass kept running");

	property p_alt;
		ce_i & alt & term[1] |=> tctrl_reg[0].en;
	endproperty
	a_alt: assert property (p_alt) else $error("partner not enabled");

	property p_comb;
		ce_i & tx & shared_reg.pin_sel |=> combined_out_pin_o == $past(comb);
	endproperty
	a_comb: assert property (p_comb) else $error("combined pin wrong");

	property p_pinb;
		ce_i & capt & shared_reg.pin_sel & ~pin_b_mask_i |=> pin_b_interrupt_o;
	endproperty
	a_pinb: assert property (p_pinb) else $error("pin b interrupt missing");

	c_alt:  cover property (alt & term[0] ##[1:1000] term[1]);
	c_irq:  cover property (timer16_irq_o);
	c_capt: cover property (capt & shared_reg.pin_sel);
	c_wr:   cover property (we_sh);
endmodule

// ===== dct_ir_model.sv
/*
 * far-side model: infrared receiver lines feeding the two demodulation pins.
 * assumes calls of pulse right after a rising edge of clk_i.
 */
`timescale 1ns/100ps
module dct_ir_model (
	input  wire logic clk_i,
	output logic      pin_a_o,
	output logic      pin_b_o
);
	// receiver lines idle high, pulled up
	initial begin
		pin_a_o = 1'b1;
		pin_b_o = 1'b1;
	end
	// low pulse of w cycles on one line, then idle
	task automatic pulse(input logic sel_b, input int w);
		if (sel_b) pin_b_o <= 1'b0;
		else pin_a_o <= 1'b0;
		repeat (w) @(posedge clk_i);
		pin_a_o <= 1'b1;
		pin_b_o <= 1'b1;
		repeat (24) @(posedge clk_i);
	endtask
endmodule

// ===== dct_timer_pair_tb_top.sv
/*
 * bench of the carrier timer pair: registers, counting, merge, demodulation.
 * assumes the design files and the ir model are compiled before it.
 */
`timescale 1ns/100ps
module dct_timer_pair_tb_top;
	logic        clk_i   = 1'b0;
	logic        rst_n_i = 1'b0;
	logic        rd      = 1'b0;
	logic        wr      = 1'b0;
	logic        mask    = 1'b0;
	logic        ce      = 1'b1;
	logic [4:0]  adr     = 5'h00;
	logic [31:0] wd      = 32'h0;
	logic [2:0]  pd      = 3'h5;
	logic [31:0] rdata;
	logic        wait_o, p8, p16, pc, i8, i16, ib, pa, pb;
	logic [7:0]  q;
	int          fail_count = 0, num_checks = 0, n8 = 0, n16 = 0, nb = 0;
	int          k, a8, a16, ab;
	// addr, write data, read back
	logic [20:0] rows [8] = '{{5'h00, 8'h1e, 8'h1e}, {5'h04, 8'h32, 8'h32},
		{5'h08, 8'h0e, 8'h0e}, {5'h08, 8'h2c, 8'h0c}, {5'h0c, 8'ha5, 8'ha5},
		{5'h10, 8'h5a, 8'h5a}, {5'h14, 8'h3c, 8'h3c}, {5'h18, 8'hff, 8'h00}};

	always #5 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		n8  <= n8 + int'(i8 === 1'b1);
		n16 <= n16 + int'(i16 === 1'b1);
		nb  <= nb + int'(ib === 1'b1);
	end

	dct_ir_model ir_u (.clk_i(clk_i), .pin_a_o(pa), .pin_b_o(pb));
	dct_timer_pair dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce), .address_i(adr),
		.read_i(rd), .write_i(wr), .writedata_i(wd), .byteenable_i(4'h1),
		.readdata_o(rdata), .waitrequest_o(wait_o), .port_data_i(pd),
		.demod_pin_a_i(pa), .demod_pin_b_i(pb), .pin_b_mask_i(mask),
		.timer8_out_pin_o(p8), .timer16_out_pin_o(p16), .combined_out_pin_o(pc),
		.timer8_irq_o(i8), .timer16_irq_o(i16), .pin_b_interrupt_o(ib));

	// ****************************************
	// tasks
	// ****************************************
	task automatic close_out;
		if (fail_count == 0 && num_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	// one Avalon access, held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
		int n;
		n = 0;
		adr <= a;
		wr <= w;
		rd <= ~w;
		wd <= {24'h0, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (wait_o !== 1'b0 && n < 40);
		q = rdata[7:0];
		if (n >= 40) begin
			fail_count++;
			close_out();
		end
		wr <= 1'b0;
		rd <= 1'b0;
		@(posedge clk_i);
	endtask
	// cycles until timer16 pin reaches v
	task automatic wait16(input logic v, output int c);
		c = 0;
		while (p16 !== v && c < 300) begin
			@(posedge clk_i);
			c++;
		end
		if (c >= 300) begin
			fail_count++;
			close_out();
		end
	endtask

	initial begin
		#900000;
		fail_count++;
		close_out();
	end

	// ****************************************
	// sequence
	// ****************************************
	initial begin
		repeat (8) @(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		chk({5'h0, p8, p16, pc}, 8'h05, "port pins");
		// clock enable low freezes the pins
		ce <= 1'b0;
		pd <= 3'h2;
		repeat (3) @(posedge clk_i);
		chk({5'h0, p8, p16, pc}, 8'h05, "frozen pins");
		ce <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk({5'h0, p8, p16, pc}, 8'h02, "port follow");
		pd <= 3'h5;
		for (int i = 0; i < 6; i++) begin
			bus(1'b0, 5'(i * 4), 8'h00);
			chk(q, 8'h00, "reset value");
		end
		foreach (rows[i]) begin
			bus(1'b1, rows[i][20:16], rows[i][15:8]);
			bus(1'b0, rows[i][20:16], 8'h00);
			chk(q, rows[i][7:0], "readback");
		end
		bus(1'b1, 5'h00, 8'h01);
		bus(1'b1, 5'h04, 8'h00);
		bus(1'b1, 5'h08, 8'h01);
		repeat (3) @(posedge clk_i);
		chk({6'h0, p8, p16}, 8'h03, "idle outputs");
		bus(1'b1, 5'h04, 8'h01);
		repeat (3) @(posedge clk_i);
		chk({7'h0, p16}, 8'h00, "idle inverse");
		// modulo-N timer16, half period reload+1
		bus(1'b1, 5'h04, 8'h00);
		bus(1'b1, 5'h0c, 8'h00);
		bus(1'b1, 5'h10, 8'h03);
		bus(1'b1, 5'h08, 8'h83);
		wait16(1'b0, k);
		wait16(1'b1, k);
		wait16(1'b0, k);
		chk(8'(k), 8'h04, "half period");
		a16 = n16;
		repeat (40) @(posedge clk_i);
		chk(8'(n16 - a16), 8'h0a, "timer16 pulses");
		bus(1'b0, 5'h08, 8'h00);
		chk(q, 8'ha3, "status set");
		bus(1'b1, 5'h10, 8'h07);
		wait16(~p16, k);
		wait16(~p16, k);
		wait16(~p16, k);
		chk(8'(k), 8'h08, "new reload");
		bus(1'b1, 5'h08, 8'h01);
		// single-pass timer8
		bus(1'b1, 5'h14, 8'h05);
		a8 = n8;
		bus(1'b1, 5'h00, 8'hc3);
		repeat (20) @(posedge clk_i);
		bus(1'b0, 5'h00, 8'h00);
		chk(q, 8'h63, "single stop");
		chk(8'(n8 - a8), 8'h01, "timer8 pulses");
		chk({7'h0, p8}, 8'h01, "timer8 stopped out");
		// merge functions with timer16 forced, timer8 idle high
		for (int f = 0; f < 4; f++) begin
			for (int s = 2; s < 4; s++) begin
				bus(1'b1, 5'h04, 8'(8'h40 | (f << 4) | (s << 2)));
				repeat (3) @(posedge clk_i);
				chk({7'h0, p16}, 8'(s & 1), "forced");
				chk({7'h0, pc}, 8'((f == 1) | ((f == 0) & s) | ((f == 3) & ~s) & 1), "merge");
			end
		end
		bus(1'b1, 5'h04, 8'h08);
		repeat (3) @(posedge clk_i);
		chk({7'h0, pc}, {7'h0, pd[2]}, "port pin");
		// alternating mode: both single-pass, start timer8
		bus(1'b1, 5'h10, 8'h03);
		bus(1'b1, 5'h14, 8'h03);
		bus(1'b1, 5'h08, 8'h42);
		bus(1'b1, 5'h00, 8'h42);
		bus(1'b1, 5'h04, 8'h04);
		a8 = n8;
		a16 = n16;
		bus(1'b1, 5'h00, 8'hc2);
		repeat (60) @(posedge clk_i);
		chk({7'h0, n8 - a8 > 2}, 8'h01, "timer8 alternates");
		chk({7'h0, n16 - a16 > 2}, 8'h01, "timer16 alternates");
		bus(1'b1, 5'h04, 8'h00);
		bus(1'b1, 5'h00, 8'h00);
		bus(1'b1, 5'h08, 8'h00);
		// demodulation on pin b, falling edge, filter 4
		bus(1'b1, 5'h04, 8'hc4);
		ab = nb;
		ir_u.pulse(1'b1, 2);
		chk(8'(nb - ab), 8'h00, "glitch");
		ir_u.pulse(1'b1, 10);
		chk(8'(nb - ab), 8'h01, "pin b event");
		bus(1'b0, 5'h04, 8'h00);
		chk(q, 8'hc5, "falling flag");
		bus(1'b1, 5'h04, 8'hc5);
		bus(1'b0, 5'h04, 8'h00);
		chk(q, 8'hc4, "flag cleared");
		mask <= 1'b1;
		ir_u.pulse(1'b1, 10);
		chk(8'(nb - ab), 8'h01, "masked");
		mask <= 1'b0;
		bus(1'b1, 5'h04, 8'h85);
		ir_u.pulse(1'b0, 10);
		bus(1'b0, 5'h04, 8'h00);
		chk(q, 8'h85, "pin a flag");
		chk(8'(nb - ab), 8'h01, "pin a no irq");
		// both edges on pin b, then a pulse under the widest filter
		bus(1'b1, 5'h04, 8'he4);
		ir_u.pulse(1'b1, 10);
		chk(8'(nb - ab), 8'h03, "both edges");
		bus(1'b1, 5'h04, 8'hcc);
		ir_u.pulse(1'b1, 10);
		chk(8'(nb - ab), 8'h03, "wide filter");
		// reset in mid-run
		rst_n_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		chk({5'h0, p8, p16, pc}, 8'h05, "pins after reset");
		bus(1'b0, 5'h04, 8'h00);
		chk(q, 8'h00, "shared after reset");
		close_out();
	end
endmodule
